/* rtl/apm_power_map.svh */
// Register offsets, field positions, reset values and timing figures of the
// activity power manager. Included by the design module.
`ifndef APM_POWER_MAP_SVH
`define APM_POWER_MAP_SVH

// Register offsets (index space)
`define APM_OFS_SYS_ACT_A 8'h62
`define APM_OFS_SYS_ACT_B 8'h63
`define APM_OFS_SYS_ACT_C 8'h64
`define APM_OFS_HK_A 8'h65
`define APM_OFS_HK_B 8'h66
`define APM_OFS_PERIPH_IDLE 8'h67
`define APM_OFS_TRAP_A 8'h69
`define APM_OFS_TRAP_B 8'h6A
`define APM_OFS_RANGE_HIGH 8'h6B
`define APM_OFS_RANGE_LOW 8'h6C
`define APM_OFS_DOZE_SEL 8'h8D

// Reset value shared by every register
`define APM_RST_REG 8'h00

// Writable bit masks; other bits read as zero
`define APM_MASK_SYS_ACT_A 8'hFE
`define APM_MASK_RANGE_BIT 8'h20
`define APM_MASK_SYS_ACT_C 8'hE0
`define APM_MASK_HK_A 8'hFC
`define APM_MASK_PERIPH 8'hFC
`define APM_MASK_DOZE_SEL 8'hE0

// Field positions
`define APM_DOZE_CODE_LSB 5
`define APM_PERIPH_LSB 2
`define APM_RANGE_MEM_BIT 0
`define APM_RANGE_WIDE_BIT 1
`define APM_RANGE_B2_BIT 2

// Timing: clock period in nanoseconds, tick and doze durations in milliseconds
`define APM_CLK_PERIOD_NS 10
`define APM_TICK_MS 1
`define APM_DOZE_CODE1_MS 50
`define APM_DOZE_CODE2_MS 100
`define APM_DOZE_CODE3_MS 500
`define APM_DOZE_CODE5_MS 4000
`define APM_DOZE_CODE6_MS 8000
`define APM_DOZE_CODE7_MS 16000

`endif

/* rtl/apm_power_mgr.sv */
// Activity monitor, doze timer and address-range comparator of the power
// management unit. Expects synchronous activity levels, one-cycle control
// pulses from the SMI and timer logic kept elsewhere, and a strobe port bus.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`include "apm_power_map.svh"

// Functional notes
// - Doze code in bits 7-5; zero or reserved 4 disables, else expiry raises SMI or dozes.
// - Codes 1,2,3,5,6,7 give 50ms,100ms,500ms,4s,8s,16s; code 4 reserved.
// - Enabled system activity restarts the doze countdown from programmed value.
// - Doze timer counts only while enabled and its timeout flag is clear.
// - System enable A: bits 7..1 DMA, PCI master, parallel, serial, kbd, floppy, disk.
// - System activity reloads timers, raises SMI, or auto-returns to power-on.
// - System enable B bit 5 enables range 0; other bits written zero.
// - System enable C: bit 7 IRQ15, bit 6 IRQ0, bit 5 NMI; reset clears.
// - House-keeping activity only in doze, standby or house-keeping; returns power for a while.
// - House-keeping A: bits 7..2 DMA, PCI master, kbd, IRQ15, IRQ0, NMI.
// - House-keeping B bit 5 enables range 0; other bits written zero.
// - Idle enable: bits 7..2 parallel, serial, kbd, floppy, disk, range 0.
// - Enabled peripheral idle for a whole peripheral period raises SMI.
// - Trap enable uses bits 7..2; access to enabled peripheral raises SMI.
// - Range high byte matches address 31-24 for memory, 15-8 for I/O.
// - Range low bits 7-3 match address 23-19 for memory, 7-3 for I/O.
// - Range low bit 0 selects memory cycles when one, I/O when zero.
// - SMI control chooses doze expiry outcome: SMI when set, auto doze when clear.
module apm_power_mgr #(
  parameter int MS_CYCLES = `APM_TICK_MS * 1000000 / `APM_CLK_PERIOD_NS
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire apm_power_pkg::apm_act_s act_in,
  input wire apm_power_pkg::apm_pci_s pci_in,
  input wire apm_power_pkg::apm_smi_ctl_s smi_ctl_in,
  input wire logic doze_flag_clear_in,
  input wire logic standby_enter_in,
  input wire logic hk_timeout_in,
  input wire logic periph_timeout_in,
  output logic smi_req_out,
  output logic doze_timeout_out,
  output logic timer_reload_out,
  output logic hk_enter_out,
  output logic trap_out,
  output logic [7:0] periph_idle_out,
  output logic [1:0] power_state_out
);

  // The prescaler must produce a tick no faster than every other cycle
  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("MS_CYCLES must be at least 2");
  end

  apm_power_pkg::apm_regs_s st_ff;
  apm_power_pkg::apm_regs_s nxt_st;

  // Doze code to milliseconds; reserved and disabled codes give zero
  function automatic logic [13:0] doze_load_ms(input logic [2:0] code);
    case (code)
      3'h1: doze_load_ms = 14'(`APM_DOZE_CODE1_MS);
      3'h2: doze_load_ms = 14'(`APM_DOZE_CODE2_MS);
      3'h3: doze_load_ms = 14'(`APM_DOZE_CODE3_MS);
      3'h5: doze_load_ms = 14'(`APM_DOZE_CODE5_MS);
      3'h6: doze_load_ms = 14'(`APM_DOZE_CODE6_MS);
      3'h7: doze_load_ms = 14'(`APM_DOZE_CODE7_MS);
      default: doze_load_ms = 14'h0000;
    endcase
  endfunction

  // Range compare against one PCI cycle
  function automatic logic range_match(input logic [7:0] hi, input logic [7:0] lo,
                                       input apm_power_pkg::apm_pci_s cyc);
    logic hit;
    hit = 1'b0;
    if (lo[`APM_RANGE_MEM_BIT]) begin
      hit = cyc.is_mem && (cyc.addr[31:24] == hi)
            && (cyc.addr[23:19] == lo[7:3])
            && (cyc.addr[18] == lo[`APM_RANGE_B2_BIT])
            && (cyc.addr[17] == lo[`APM_RANGE_WIDE_BIT]);
    end else if (!cyc.is_mem && (cyc.addr[15:8] == hi)) begin
      if (!lo[`APM_RANGE_WIDE_BIT]) begin
        // 4-byte window: bits 7-2 all matter
        hit = (cyc.addr[7:3] == lo[7:3]) && (cyc.addr[2] == lo[`APM_RANGE_B2_BIT]);
      end else if (lo[`APM_RANGE_B2_BIT]) begin
        // 16-byte window ignores address bit 3
        hit = (cyc.addr[7:4] == lo[7:4]);
      end else begin
        hit = (cyc.addr[7:3] == lo[7:3]);
      end
    end
    range_match = hit;
  endfunction

  // Combinational event terms
  apm_power_pkg::apm_act_s act_pulse;
  logic range_now;
  logic range_pulse;
  logic [7:0] sys_a_hit;
  logic sys_b_hit;
  logic [2:0] sys_c_hit;
  logic sys_event;
  logic [5:0] hk_a_hit;
  logic hk_b_hit;
  logic hk_event;
  logic [5:0] periph_pulse;
  logic [5:0] trap_hit;
  logic [13:0] doze_load;
  logic doze_enabled;
  logic ms_tick;
  logic doze_expire;
  logic powered_down;
  logic [5:0] idle_now;

  // Rising edges of the activity levels become single pulses
  always_comb begin
    act_pulse = act_in & ~st_ff.act_prev;
    range_now = pci_in.valid && range_match(st_ff.range_high, st_ff.range_low, pci_in);
    range_pulse = range_now && !st_ff.range_prev;
    periph_pulse = {act_pulse.parallel_port_activity, act_pulse.serial_port_activity,
                    act_pulse.keyboard_activity, act_pulse.floppy_activity,
                    act_pulse.hard_disk_activity, range_pulse};
  end

  // Enabled system and house-keeping events
  always_comb begin
    sys_a_hit = st_ff.sys_act_a & {act_pulse.dma_request_activity,
                                   act_pulse.pci_master_activity,
                                   act_pulse.parallel_port_activity,
                                   act_pulse.serial_port_activity,
                                   act_pulse.keyboard_activity,
                                   act_pulse.floppy_activity,
                                   act_pulse.hard_disk_activity, 1'b0};
    sys_b_hit = st_ff.sys_act_b[5] && range_pulse;
    sys_c_hit = st_ff.sys_act_c[7:5] & {act_pulse.irq15_activity,
                                        act_pulse.irq0_activity, act_pulse.nmi_activity};
    sys_event = (|sys_a_hit) || sys_b_hit || (|sys_c_hit);
    hk_a_hit = st_ff.hk_a[7:2] & {act_pulse.dma_request_activity,
                                  act_pulse.pci_master_activity,
                                  act_pulse.keyboard_activity, act_pulse.irq15_activity,
                                  act_pulse.irq0_activity, act_pulse.nmi_activity};
    hk_b_hit = st_ff.hk_b[5] && range_pulse;
    powered_down = (st_ff.state == apm_power_pkg::APM_DOZE)
                   || (st_ff.state == apm_power_pkg::APM_STANDBY)
                   || (st_ff.state == apm_power_pkg::APM_HOUSEKEEP);
    // An activity counts as system or house-keeping, never both
    hk_event = ((|hk_a_hit) || hk_b_hit) && powered_down && !sys_event;
    trap_hit = st_ff.trap_a[7:2] & periph_pulse;
    idle_now = st_ff.periph_idle_en[7:2] & ~(st_ff.periph_seen | periph_pulse);
  end

  // Doze timer terms
  always_comb begin
    doze_load = doze_load_ms(st_ff.doze_sel[7:`APM_DOZE_CODE_LSB]);
    doze_enabled = (doze_load != 14'h0000);
    ms_tick = (st_ff.prescale == 32'(MS_CYCLES - 1));
    doze_expire = doze_enabled && !st_ff.doze_timeout && ms_tick
                  && (st_ff.doze_count == 14'h0001);
  end

  // Next state of the whole unit
  always_comb begin
    nxt_st = st_ff;
    nxt_st.act_prev = act_in;
    nxt_st.range_prev = range_now;
    nxt_st.smi_req = 1'b0;
    nxt_st.timer_reload = 1'b0;
    nxt_st.hk_enter = 1'b0;
    nxt_st.trap = 1'b0;
    nxt_st.rdata = 8'h00;

    // Register reads: data appears one cycle later, unmapped reads give zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        `APM_OFS_SYS_ACT_A: nxt_st.rdata = st_ff.sys_act_a;
        `APM_OFS_SYS_ACT_B: nxt_st.rdata = st_ff.sys_act_b;
        `APM_OFS_SYS_ACT_C: nxt_st.rdata = st_ff.sys_act_c;
        `APM_OFS_HK_A: nxt_st.rdata = st_ff.hk_a;
        `APM_OFS_HK_B: nxt_st.rdata = st_ff.hk_b;
        `APM_OFS_PERIPH_IDLE: nxt_st.rdata = st_ff.periph_idle_en;
        `APM_OFS_TRAP_A: nxt_st.rdata = st_ff.trap_a;
        `APM_OFS_RANGE_HIGH: nxt_st.rdata = st_ff.range_high;
        `APM_OFS_RANGE_LOW: nxt_st.rdata = st_ff.range_low;
        `APM_OFS_DOZE_SEL: nxt_st.rdata = st_ff.doze_sel;
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // Register writes; reserved bits are dropped so they read as zero
    if (reg_wr_in) begin
      case (reg_addr_in)
        `APM_OFS_SYS_ACT_A: nxt_st.sys_act_a = reg_wdata_in & `APM_MASK_SYS_ACT_A;
        `APM_OFS_SYS_ACT_B: nxt_st.sys_act_b = reg_wdata_in & `APM_MASK_RANGE_BIT;
        `APM_OFS_SYS_ACT_C: nxt_st.sys_act_c = reg_wdata_in & `APM_MASK_SYS_ACT_C;
        `APM_OFS_HK_A: nxt_st.hk_a = reg_wdata_in & `APM_MASK_HK_A;
        `APM_OFS_HK_B: nxt_st.hk_b = reg_wdata_in & `APM_MASK_RANGE_BIT;
        `APM_OFS_PERIPH_IDLE: nxt_st.periph_idle_en = reg_wdata_in & `APM_MASK_PERIPH;
        `APM_OFS_TRAP_A: nxt_st.trap_a = reg_wdata_in & `APM_MASK_PERIPH;
        `APM_OFS_RANGE_HIGH: nxt_st.range_high = reg_wdata_in;
        `APM_OFS_RANGE_LOW: nxt_st.range_low = reg_wdata_in;
        `APM_OFS_DOZE_SEL: nxt_st.doze_sel = reg_wdata_in & `APM_MASK_DOZE_SEL;
        default: nxt_st.rdata = nxt_st.rdata; // Trap enable B and unmapped: no effect
      endcase
    end

    // Free-running millisecond prescaler
    nxt_st.prescale = ms_tick ? 32'h00000000 : st_ff.prescale + 32'h00000001;

    // Doze countdown: clear when disabled, hold while the flag is set
    if (!doze_enabled) begin
      nxt_st.doze_count = 14'h0000;
    end else if (sys_event || st_ff.doze_count == 14'h0000) begin
      nxt_st.doze_count = doze_load;
    end else if (!st_ff.doze_timeout && ms_tick) begin
      nxt_st.doze_count = st_ff.doze_count - 14'h0001;
    end

    // Software clear of the doze flag, beaten by a new expiry in the same cycle
    if (doze_flag_clear_in) begin
      nxt_st.doze_timeout = 1'b0;
    end
    if (doze_expire && !sys_event) begin
      nxt_st.doze_timeout = 1'b1;
      nxt_st.doze_count = doze_load;
      if (smi_ctl_in.smi_on_doze) begin
        nxt_st.smi_req = 1'b1;
      end else if (st_ff.state == apm_power_pkg::APM_ON) begin
        nxt_st.state = apm_power_pkg::APM_DOZE;
      end
    end

    // Standby entry requested by the standby timer logic
    if (standby_enter_in && (st_ff.state != apm_power_pkg::APM_HOUSEKEEP)) begin
      nxt_st.state = apm_power_pkg::APM_STANDBY;
    end

    // House-keeping timeout: SMI, or a return to the state it interrupted
    if (hk_timeout_in && (st_ff.state == apm_power_pkg::APM_HOUSEKEEP)) begin
      if (smi_ctl_in.smi_on_hk_timeout) begin
        nxt_st.smi_req = 1'b1;
      end else begin
        nxt_st.state = st_ff.hk_return;
      end
    end

    // House-keeping activity: SMI or a short return to full power
    if (hk_event) begin
      if (smi_ctl_in.smi_on_hk_activity) begin
        nxt_st.smi_req = 1'b1;
      end else begin
        nxt_st.hk_enter = 1'b1;
        nxt_st.state = apm_power_pkg::APM_HOUSEKEEP;
        if (st_ff.state != apm_power_pkg::APM_HOUSEKEEP) begin
          nxt_st.hk_return = st_ff.state;
        end
      end
    end

    // System activity: reload timers, then SMI or automatic wake-up
    if (sys_event) begin
      nxt_st.timer_reload = 1'b1;
      if (smi_ctl_in.smi_on_sys_activity) begin
        nxt_st.smi_req = 1'b1;
      end else if (powered_down) begin
        nxt_st.state = apm_power_pkg::APM_ON;
        // Wake-up clears the doze flag; an expiry cannot set it in the same cycle
        nxt_st.doze_timeout = 1'b0;
      end
    end

    // Peripheral idle tracking across one peripheral period
    nxt_st.periph_seen = st_ff.periph_seen | periph_pulse;
    if (periph_timeout_in) begin
      nxt_st.periph_idle = {idle_now, 2'b00};
      nxt_st.periph_seen = 6'h00;
      if (|idle_now) begin
        nxt_st.smi_req = 1'b1;
      end
    end

    // Access trap to a powered-down peripheral
    if (|trap_hit) begin
      nxt_st.trap = 1'b1;
      nxt_st.smi_req = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_ff <= '{
        sys_act_a: `APM_RST_REG,
        sys_act_b: `APM_RST_REG,
        sys_act_c: `APM_RST_REG,
        hk_a: `APM_RST_REG,
        hk_b: `APM_RST_REG,
        periph_idle_en: `APM_RST_REG,
        trap_a: `APM_RST_REG,
        range_high: `APM_RST_REG,
        range_low: `APM_RST_REG,
        doze_sel: `APM_RST_REG,
        rdata: 8'h00,
        act_prev: '0,
        range_prev: 1'b0,
        periph_seen: 6'h00,
        periph_idle: 8'h00,
        prescale: 32'h00000000,
        doze_count: 14'h0000,
        doze_timeout: 1'b0,
        state: apm_power_pkg::APM_ON,
        hk_return: apm_power_pkg::APM_ON,
        smi_req: 1'b0,
        timer_reload: 1'b0,
        hk_enter: 1'b0,
        trap: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs taken straight from the state register
  assign reg_rdata_out = st_ff.rdata;
  assign smi_req_out = st_ff.smi_req;
  assign doze_timeout_out = st_ff.doze_timeout;
  assign timer_reload_out = st_ff.timer_reload;
  assign hk_enter_out = st_ff.hk_enter;
  assign trap_out = st_ff.trap;
  assign periph_idle_out = st_ff.periph_idle;
  assign power_state_out = st_ff.state;

endmodule

/* rtl/apm_power_pkg.sv */
// Types shared by the activity power manager and its surroundings.
// Assumes the map header sits beside it in rtl/.
package apm_power_pkg;

  // Power state of the unit
  typedef enum logic [1:0] {
    APM_ON,
    APM_DOZE,
    APM_STANDBY,
    APM_HOUSEKEEP
  } apm_state_e;

  // Activity sources as active-high levels from the decoders
  typedef struct packed {
    logic dma_request_activity;
    logic pci_master_activity;
    logic parallel_port_activity;
    logic serial_port_activity;
    logic keyboard_activity;
    logic floppy_activity;
    logic hard_disk_activity;
    logic irq15_activity;
    logic irq0_activity;
    logic nmi_activity;
  } apm_act_s;

  // One observed PCI cycle
  typedef struct packed {
    logic valid;
    logic is_mem;
    logic [31:0] addr;
  } apm_pci_s;

  // SMI control selections held elsewhere
  typedef struct packed {
    logic smi_on_doze;
    logic smi_on_hk_timeout;
    logic smi_on_hk_activity;
    logic smi_on_sys_activity;
  } apm_smi_ctl_s;

  // Whole register state of the unit
  typedef struct packed {
    logic [7:0] sys_act_a;
    logic [7:0] sys_act_b;
    logic [7:0] sys_act_c;
    logic [7:0] hk_a;
    logic [7:0] hk_b;
    logic [7:0] periph_idle_en;
    logic [7:0] trap_a;
    logic [7:0] range_high;
    logic [7:0] range_low;
    logic [7:0] doze_sel;
    logic [7:0] rdata;
    apm_act_s act_prev;
    logic range_prev;
    logic [5:0] periph_seen;
    logic [7:0] periph_idle;
    logic [31:0] prescale;
    logic [13:0] doze_count;
    logic doze_timeout;
    apm_state_e state;
    apm_state_e hk_return;
    logic smi_req;
    logic timer_reload;
    logic hk_enter;
    logic trap;
  } apm_regs_s;

endpackage

/* tb/activity_power_manager_tb_top.sv */
// Self-checking bench for the activity power manager with a host model.
// Assumes package, map header and design are compiled first.
`timescale 1ns/1ns
module activity_power_manager_tb_top;
  localparam int MSC = 2;
  localparam logic [7:0] AL [12] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h69,
    8'h6A, 8'h6B, 8'h6C, 8'h8D, 8'h70};
  localparam int DMS [8] = '{0, 50, 100, 500, 0, 4000, 8000, 16000};
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [3:0] ctl4 = 4'h0;
  logic fire = 1'b0;
  logic [3:0] sel = 4'h0;
  apm_power_pkg::apm_smi_ctl_s smi_ctl_in = '0;
  apm_power_pkg::apm_pci_s cyc = '0;
  apm_power_pkg::apm_act_s act_in;
  apm_power_pkg::apm_pci_s pci_in;
  logic [7:0] reg_rdata_out, periph_idle_out;
  logic smi_req_out, doze_timeout_out, timer_reload_out, hk_enter_out, trap_out;
  logic [1:0] power_state_out;
  int smi_cnt;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 31437;
  apm_power_mgr #(.MS_CYCLES(MSC)) DUT (
    .sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .act_in, .pci_in, .smi_ctl_in, .doze_flag_clear_in(ctl4[0]),
    .standby_enter_in(ctl4[1]), .hk_timeout_in(ctl4[2]), .periph_timeout_in(ctl4[3]),
    .smi_req_out, .doze_timeout_out, .timer_reload_out, .hk_enter_out, .trap_out,
    .periph_idle_out, .power_state_out);
  apm_host_model u_host (.sys_clk_in, .fire_in(fire), .sel_in(sel), .cyc_in(cyc),
    .smi_req_in(smi_req_out), .act_out(act_in), .pci_out(pci_in), .smi_count_out(smi_cnt));
  // Free-running 100 MHz clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Cut a hang short well past the longest doze sequence
  initial begin
    repeat (80000) @(posedge sys_clk_in);
    bad_count++;
    summarize();
  end
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Writable bits per index; reserved and unmapped places read zero
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h62: msk = 8'hFE;
      8'h63, 8'h66: msk = 8'h20;
      8'h64, 8'h8D: msk = 8'hE0;
      8'h65, 8'h67, 8'h69: msk = 8'hFC;
      8'h6B, 8'h6C: msk = 8'hFF;
      default: msk = 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk("rdata", reg_rdata_out, exp);
  endtask
  task automatic setctl(input logic [3:0] v);
    @(posedge sys_clk_in);
    smi_ctl_in <= v;
  endtask
  // Host request; returns when the unit's answer is visible
  task automatic ev(input logic [3:0] s);
    @(posedge sys_clk_in);
    fire <= 1'b1;
    sel <= s;
    @(posedge sys_clk_in);
    fire <= 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk_in);
    ctl4 <= 4'(1 << k);
    @(posedge sys_clk_in);
    ctl4 <= 4'h0;
    #1;
  endtask
  task automatic wait_doze(input int lim, output int n);
    n = 0;
    while (doze_timeout_out !== 1'b1 && n < lim) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
  endtask
  // Main sequence
  initial begin
    logic [7:0] v, ena, enc, hi;
    logic [4:0] lo;
    int n, base;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    foreach (AL[i]) rd_chk(AL[i], 8'h00);
    foreach (AL[i]) begin
      v = 8'($random(seed));
      // Bits that software must program to zero stay zero
      if (AL[i] inside {8'h63, 8'h66, 8'h67, 8'h69, 8'h6A}) v = v & msk(AL[i]);
      wr(AL[i], v);
      rd_chk(AL[i], v & msk(AL[i]));
      wr(AL[i], 8'h00);
    end
    // Every source with random enables, then all enabled with SMI on activity
    for (int r = 0; r < 2; r++) begin
      ena = r ? 8'hFE : 8'($random(seed)) & 8'hFE;
      enc = r ? 8'hE0 : 8'($random(seed)) & 8'hE0;
      setctl({3'b000, r[0]});
      wr(8'h62, ena);
      wr(8'h64, enc);
      for (int s = 0; s < 10; s++) begin
        ev(s[3:0]);
        v[0] = s > 2 ? ena[s - 2] : enc[s + 5];
        chk("reload", timer_reload_out, v[0]);
        chk("sys smi", smi_req_out, v[0] & r[0]);
      end
    end
    setctl(4'h0);
    // Range hits, then one-bit misses, for I/O and memory cycles
    hi = 8'($random(seed));
    lo = 5'($random(seed));
    wr(8'h63, 8'h20);
    wr(8'h6B, hi);
    for (int m = 0; m < 2; m++) begin
      wr(8'h6C, {lo, 2'b00, m[0]});
      cyc = m ? {2'b11, hi, lo, 19'h0} : {2'b10, 16'h0, hi, lo, 3'h0};
      ev(4'hA);
      chk("range hit", timer_reload_out, 1'b1);
      cyc.addr = cyc.addr ^ (m ? 32'h0100_0000 : 32'h0000_0008);
      ev(4'hA);
      chk("range miss", timer_reload_out, 1'b0);
    end
    wr(8'h69, 8'h80);
    ev(4'h7);
    chk("trap", {trap_out, smi_req_out}, 2'b11);
    ev(4'h6);
    chk("no trap", trap_out, 1'b0);
    wr(8'h69, 8'h00);
    // Idle report over one whole period, then with enables cleared
    wr(8'h67, 8'hFC);
    pulse(3);
    ev(4'h7);
    pulse(3);
    chk("idle", {periph_idle_out, smi_req_out}, 9'h0F9);
    wr(8'h67, 8'h00);
    pulse(3);
    chk("idle off", smi_req_out, 1'b0);
    // Every doze code with SMI on expiry; disabled codes never expire
    setctl(4'h8);
    base = smi_cnt;
    foreach (DMS[c]) begin
      wr(8'h8D, 8'(c << 5));
      wait_doze(DMS[c] ? DMS[c] * MSC + MSC + 4 : 300, n);
      chk("doze time", DMS[c] ? (n >= DMS[c] * MSC - 2 && n <= DMS[c] * MSC + MSC + 4)
        : n == 300, 1'b1);
      wr(8'h8D, 8'h00);
      chk("doze hold", doze_timeout_out, DMS[c] != 0);
      pulse(0);
    end
    chk("doze smi", smi_cnt - base, 6);
    wr(8'h8D, 8'h20);
    repeat (60) @(posedge sys_clk_in);
    ev(4'h9);
    wait_doze(200, n);
    chk("doze restart", n >= 50 * MSC - 4 && n <= 50 * MSC + MSC + 4, 1'b1);
    wr(8'h8D, 8'h00);
    pulse(0);
    // Automatic doze, house-keeping round trip, standby, then a wake that wins
    setctl(4'h0);
    wr(8'h62, 8'h00);
    wr(8'h65, 8'hFC);
    ev(4'h5);
    chk("hk in on", {hk_enter_out, power_state_out}, 3'h0);
    wr(8'h8D, 8'h20);
    wait_doze(200, n);
    wr(8'h8D, 8'h00);
    chk("auto doze", power_state_out, 2'h1);
    ev(4'h5);
    chk("hk enter", {hk_enter_out, power_state_out}, 3'h7);
    pulse(2);
    chk("hk back", power_state_out, 2'h1);
    pulse(1);
    chk("standby", power_state_out, 2'h2);
    wr(8'h62, 8'h80);
    ev(4'h9);
    chk("wake", {hk_enter_out, power_state_out, doze_timeout_out}, 4'h0);
    summarize();
  end
endmodule

/* tb/apm_host_model.sv */
// Host side model: raises activity levels and PCI cycles on request, counts SMI.
// Assumes the single clock of the unit.
`timescale 1ns/1ns
module apm_host_model (
  input wire logic sys_clk_in,
  input wire logic fire_in,
  input wire logic [3:0] sel_in,
  input wire apm_power_pkg::apm_pci_s cyc_in,
  input wire logic smi_req_in,
  output apm_power_pkg::apm_act_s act_out,
  output apm_power_pkg::apm_pci_s pci_out,
  output int smi_count_out
);
  initial begin
    act_out = '0;
    pci_out = '0;
    smi_count_out = 0;
  end
  // One-cycle levels, so each request gives exactly one rising edge
  always @(posedge sys_clk_in) begin
    act_out <= (fire_in && sel_in < 4'hA) ? 10'(10'h001 << sel_in) : '0;
    if (fire_in && sel_in == 4'hA) begin
      pci_out <= cyc_in;
    end else begin
      // Idle address keeps moving so a stale match cannot look valid
      pci_out.valid <= 1'b0;
      pci_out.addr <= ~pci_out.addr;
    end
    if (smi_req_in) begin
      smi_count_out <= smi_count_out + 1;
    end
  end
endmodule

/* tb/apm_power_checker.sv */
// Concurrent checks on the activity power manager ports.
// Assumes one clock and the synchronous active-low reset of the unit.
`timescale 1ns/1ns
module apm_power_checker #(
  parameter int MS_CYCLES = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire apm_power_pkg::apm_act_s act_in,
  input wire apm_power_pkg::apm_smi_ctl_s smi_ctl_in,
  input wire logic doze_flag_clear_in,
  input wire logic smi_req_out,
  input wire logic doze_timeout_out,
  input wire logic timer_reload_out,
  input wire logic trap_out,
  input wire logic [1:0] power_state_out
);
  logic [7:0] sa_ff;
  logic [7:0] tr_ff;
  logic [7:0] dz_ff;
  // Shadows of the enables, updated at the same edge as the unit's copies
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sa_ff <= 8'h00;
      tr_ff <= 8'h00;
      dz_ff <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h62) sa_ff <= reg_wdata_in & 8'hFE;
      if (reg_addr_in == 8'h69) tr_ff <= reg_wdata_in & 8'hFC;
      if (reg_addr_in == 8'h8D) dz_ff <= reg_wdata_in & 8'hE0;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence dma_ev;
    $rose(act_in.dma_request_activity) && sa_ff[7];
  endsequence
  sequence par_trap;
    $rose(act_in.parallel_port_activity) && tr_ff[7];
  endsequence
  sequence doze_off;
    (dz_ff[7:5] == 3'h0 || dz_ff[7:5] == 3'h4) && !doze_timeout_out;
  endsequence
  rsvd_read_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h6A |->
    reg_rdata_out == 8'h00) else $error("reserved index read nonzero");
  sys_readback_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 8'h62 |->
    reg_rdata_out == $past(sa_ff)) else $error("system enable readback wrong");
  act_reload_a: assert property (dma_ev |=> timer_reload_out)
    else $error("no reload after enabled activity");
  act_wake_a: assert property (dma_ev ##0 !smi_ctl_in.smi_on_sys_activity
    && power_state_out != 2'h0 |=> power_state_out == 2'h0 && !doze_timeout_out)
    else $error("no wake after activity");
  act_smi_a: assert property (dma_ev ##0 smi_ctl_in.smi_on_sys_activity |=> smi_req_out)
    else $error("no smi after activity");
  trap_hit_a: assert property (par_trap |=> trap_out && smi_req_out)
    else $error("enabled access not trapped");
  trap_off_a: assert property (tr_ff == 8'h00 |=> !trap_out)
    else $error("trap with all enables clear");
  doze_off_a: assert property (doze_off |=> !doze_timeout_out)
    else $error("disabled doze timer expired");
  doze_hold_a: assert property (doze_timeout_out && !doze_flag_clear_in && act_in == '0
    |=> doze_timeout_out) else $error("doze flag dropped");
  doze_smi_a: assert property ($rose(doze_timeout_out) && smi_ctl_in.smi_on_doze
    |-> ##[0:1] smi_req_out) else $error("no smi on doze expiry");
  doze_auto_a: assert property ($rose(doze_timeout_out) && !smi_ctl_in.smi_on_doze
    && $past(power_state_out) == 2'h0
    |-> ##[0:1] power_state_out == 2'h1) else $error("no automatic doze");
endmodule
bind apm_power_mgr apm_power_checker #(.MS_CYCLES(MS_CYCLES)) u_apm_chk (
  .sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .act_in, .smi_ctl_in, .doze_flag_clear_in, .smi_req_out,
  .doze_timeout_out, .timer_reload_out, .trap_out, .power_state_out
);
